// ---- hdl/sbr_pkg.sv ----
// How it works
// - Only the wrap flag ends a ring; after it the base descriptor follows.
// - Each memory access drives that direction's four-bit qualifier code.
// - Byte order 1 puts the earlier receive byte in the word's upper byte.
// - Byte order 0 swaps byte placement, little-endian in both directions.
// - Transmit byte order 1 sends the upper byte before the lower one.
// - Never write more receive bytes than the maximum length; fewer may close.
// - Transmit byte count comes only from the transmit descriptor length.
// - A new maximum length is one 16-bit write, used at next descriptor.
// - Receive cursor reloads from its base after reset and at ring end.
// - Transmit cursor reloads from its base after reset and at ring end.
// - Down-counters load from length fields and drop once per byte moved.
// - Transmit init command resets transmit parameters, transmitter disabled.
// - Receive init command resets receive parameters, receiver disabled.
// - Close command ends the busy receive buffer; idle receiver ignores it.
// - Rings are circular queues; status is written back into descriptors.
// - A full buffer or slave deselect closes the buffer and moves on.
// - Receive descriptor is status, byte count, then buffer pointer words.
// - Empty flag gives the descriptor to the device until it is filled; with BD_CONT set it stays set.
// - Ready flag gives a transmit buffer to the device until it is sent; with BD_CONT set it stays set.
package sbr_pkg;

  localparam logic [7:0] REG_RX_BASE = 8'h00;
  localparam logic [7:0] REG_TX_BASE = 8'h02;
  localparam logic [7:0] REG_RX_QUAL = 8'h04;
  localparam logic [7:0] REG_TX_QUAL = 8'h05;
  localparam logic [7:0] REG_MAX_LEN = 8'h06;
  localparam logic [7:0] REG_RX_PTR_HI = 8'h0C;
  localparam logic [7:0] REG_RX_PTR_LO = 8'h0E;
  localparam logic [7:0] REG_RX_CUR = 8'h10;
  localparam logic [7:0] REG_RX_CNT = 8'h12;
  localparam logic [7:0] REG_TX_PTR_HI = 8'h1C;
  localparam logic [7:0] REG_TX_PTR_LO = 8'h1E;
  localparam logic [7:0] REG_TX_CUR = 8'h20;
  localparam logic [7:0] REG_TX_CNT = 8'h22;
  localparam logic [7:0] REG_CMD = 8'h30;
  localparam logic [7:0] REG_CTRL = 8'h32;
  localparam logic [7:0] REG_STAT = 8'h34;

  localparam int CMD_INIT_TX = 0;
  localparam int CMD_INIT_RX = 1;
  localparam int CMD_CLOSE_RX = 2;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_MASTER = 2;
  localparam int QUAL_ORDER = 4;

  localparam int BD_OWN = 15;
  localparam int BD_WRAP = 13;
  localparam int BD_LAST = 11;
  localparam int BD_CONT = 9;
  localparam logic [15:0] BD_STEP = 16'h0008;
  localparam logic [15:0] BD_LEN_OFS = 16'h0002;
  localparam logic [15:0] BD_PHI_OFS = 16'h0004;
  localparam logic [15:0] BD_PLO_OFS = 16'h0006;
  localparam logic [15:0] DESC_SPACE_HI = 16'h0000;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_QUAL = 8'h00;
  localparam logic [31:0] RST_PTR = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sbr_reg_req_type;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic [3:0] fc;
  } sbr_mem_cmd_type;

endpackage : sbr_pkg

// ---- hdl/sbr_ring_dma.sv ----
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
module sbr_ring_dma (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port.
  input wire sbr_pkg::sbr_reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  // Memory master.
  output logic mem_req,
  output sbr_pkg::sbr_mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Receive bytes from the shifter.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // Transmit bytes to the shifter.
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Slave select, high while selected.
  input wire logic slave_select_in
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RX_STAT, ST_RX_PHI, ST_RX_PLO, ST_RX_DATA, ST_RX_LEN,
    ST_RX_CLOSE, ST_TX_STAT, ST_TX_LEN, ST_TX_PHI, ST_TX_PLO, ST_TX_DATA,
    ST_TX_CLOSE
  } sbr_state_type;

  sbr_state_type state_r, state_nxt;
  logic rx_en_r, tx_en_r, master_r, turn_r;
  logic [15:0] rx_base_r, tx_base_r, max_len_r;
  logic [7:0] rx_qual_r, tx_qual_r;
  logic [15:0] rx_cur_r, tx_cur_r;
  logic rx_cur_ok_r, tx_cur_ok_r;
  logic [31:0] rx_ptr_r, tx_ptr_r;
  logic [15:0] rx_left_r, rx_len_r, tx_left_r;
  logic [15:0] rx_stat_r, tx_stat_r;
  logic rx_open_r, rx_hold_r, rx_close_r, rx_last_r;
  logic tx_open_r, tx_hold_r;
  logic [7:0] rx_hold_byte_r, tx_byte_r;
  logic sel_prev_r;
  logic wr, rd, init_tx, init_rx, close_cmd, ack;
  logic rx_busy, rx_take, tx_take, rx_hi, tx_hi, deselect;
  logic rx_poll, tx_poll, rx_state, tx_state;
  localparam logic [15:0] RST_WORD_C = sbr_pkg::RST_WORD;

  assign wr = reg_req.wr;
  assign rd = reg_req.rd;
  assign init_tx = wr && reg_req.addr == sbr_pkg::REG_CMD &&
    reg_req.wdata[sbr_pkg::CMD_INIT_TX];
  assign init_rx = wr && reg_req.addr == sbr_pkg::REG_CMD &&
    reg_req.wdata[sbr_pkg::CMD_INIT_RX];
  assign close_cmd = wr && reg_req.addr == sbr_pkg::REG_CMD &&
    reg_req.wdata[sbr_pkg::CMD_CLOSE_RX];
  assign ack = mem_req && mem_ack;
  assign rx_busy = rx_open_r && (rx_hold_r || rx_left_r != rx_len_r);
  assign rx_ready = rx_en_r && rx_open_r && !rx_hold_r && !rx_close_r &&
    rx_left_r != RST_WORD_C;
  assign rx_take = rx_valid && rx_ready;
  assign tx_valid = tx_hold_r;
  assign tx_byte = tx_byte_r;
  assign tx_take = tx_hold_r && tx_ready;
  // Lane choice: byte order flips which half an even address lands in.
  assign rx_hi = rx_qual_r[sbr_pkg::QUAL_ORDER] ^ rx_ptr_r[0];
  assign tx_hi = tx_qual_r[sbr_pkg::QUAL_ORDER] ^ tx_ptr_r[0];
  assign deselect = sel_prev_r && !slave_select_in && !master_r;
  assign rx_poll = rx_en_r && !rx_open_r;
  assign tx_poll = tx_en_r && !tx_open_r;
  assign rx_state = state_r inside {ST_RX_STAT, ST_RX_PHI, ST_RX_PLO,
    ST_RX_DATA, ST_RX_LEN, ST_RX_CLOSE};
  assign tx_state = state_r inside {ST_TX_STAT, ST_TX_LEN, ST_TX_PHI,
    ST_TX_PLO, ST_TX_DATA, ST_TX_CLOSE};
  assign mem_req = state_r != ST_IDLE;

  // Data moves take priority over descriptor polling so that a byte held
  // for the shifter waits at most one access behind an empty ring being polled.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (rx_open_r && rx_hold_r) begin
          state_nxt = ST_RX_DATA;
        end else if (rx_open_r && rx_close_r) begin
          state_nxt = ST_RX_LEN;
        end else if (tx_open_r && !tx_hold_r && tx_left_r != RST_WORD_C
            && tx_en_r) begin
          state_nxt = ST_TX_DATA;
        end else if (tx_open_r && !tx_hold_r &&
            tx_left_r == RST_WORD_C) begin
          state_nxt = ST_TX_CLOSE;
        end else if (rx_poll && (!tx_poll || !turn_r)) begin
          state_nxt = ST_RX_STAT;
        end else if (tx_poll) begin
          state_nxt = ST_TX_STAT;
        end
      end
      ST_RX_STAT: begin
        if (ack) begin
          state_nxt = mem_rdata[sbr_pkg::BD_OWN] ? ST_RX_PHI : ST_IDLE;
        end
      end
      ST_RX_PHI: if (ack) state_nxt = ST_RX_PLO;
      ST_RX_PLO: if (ack) state_nxt = ST_IDLE;
      ST_RX_DATA: if (ack) state_nxt = ST_IDLE;
      ST_RX_LEN: if (ack) state_nxt = ST_RX_CLOSE;
      ST_RX_CLOSE: if (ack) state_nxt = ST_IDLE;
      ST_TX_STAT: begin
        if (ack) begin
          state_nxt = mem_rdata[sbr_pkg::BD_OWN] ? ST_TX_LEN : ST_IDLE;
        end
      end
      ST_TX_LEN: if (ack) state_nxt = ST_TX_PHI;
      ST_TX_PHI: if (ack) state_nxt = ST_TX_PLO;
      ST_TX_PLO: if (ack) state_nxt = ST_IDLE;
      ST_TX_DATA: if (ack) state_nxt = ST_IDLE;
      ST_TX_CLOSE: if (ack) state_nxt = ST_IDLE;
    endcase
    if ((init_rx && rx_state) || (init_tx && tx_state)) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      turn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (ack && (state_r == ST_RX_STAT || state_r == ST_TX_STAT)) begin
        turn_r <= !turn_r;
      end
    end
  end

  // Memory command, qualified per direction.
  always_comb begin
    mem_cmd.we = 1'b0;
    mem_cmd.addr = {sbr_pkg::DESC_SPACE_HI, rx_cur_r};
    mem_cmd.wdata = RST_WORD_C;
    mem_cmd.be = 2'h3;
    mem_cmd.fc = tx_state ? tx_qual_r[3:0] : rx_qual_r[3:0];
    unique case (state_r)
      ST_RX_PHI: mem_cmd.addr[15:0] = rx_cur_r + sbr_pkg::BD_PHI_OFS;
      ST_RX_PLO: mem_cmd.addr[15:0] = rx_cur_r + sbr_pkg::BD_PLO_OFS;
      ST_RX_DATA: begin
        mem_cmd.we = 1'b1;
        mem_cmd.addr = {rx_ptr_r[31:1], 1'b0};
        mem_cmd.be = rx_hi ? 2'h2 : 2'h1;
        mem_cmd.wdata = rx_hi ? {rx_hold_byte_r, 8'h00} :
          {8'h00, rx_hold_byte_r};
      end
      ST_RX_LEN: begin
        mem_cmd.we = 1'b1;
        mem_cmd.addr[15:0] = rx_cur_r + sbr_pkg::BD_LEN_OFS;
        mem_cmd.wdata = rx_len_r - rx_left_r;
      end
      ST_RX_CLOSE: begin
        mem_cmd.we = 1'b1;
        mem_cmd.wdata = rx_stat_r;
        mem_cmd.wdata[sbr_pkg::BD_OWN] = rx_stat_r[sbr_pkg::BD_CONT];
        mem_cmd.wdata[sbr_pkg::BD_LAST] = rx_last_r;
      end
      ST_TX_STAT: mem_cmd.addr[15:0] = tx_cur_r;
      ST_TX_LEN: mem_cmd.addr[15:0] = tx_cur_r + sbr_pkg::BD_LEN_OFS;
      ST_TX_PHI: mem_cmd.addr[15:0] = tx_cur_r + sbr_pkg::BD_PHI_OFS;
      ST_TX_PLO: mem_cmd.addr[15:0] = tx_cur_r + sbr_pkg::BD_PLO_OFS;
      ST_TX_DATA: begin
        mem_cmd.addr = {tx_ptr_r[31:1], 1'b0};
        mem_cmd.be = tx_hi ? 2'h2 : 2'h1;
      end
      ST_TX_CLOSE: begin
        mem_cmd.we = 1'b1;
        mem_cmd.addr[15:0] = tx_cur_r;
        mem_cmd.wdata = tx_stat_r;
        mem_cmd.wdata[sbr_pkg::BD_OWN] = tx_stat_r[sbr_pkg::BD_CONT];
      end
      default: mem_cmd.addr[15:0] = rx_cur_r;
    endcase
  end

  // Software-written configuration.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_base_r <= RST_WORD_C;
      tx_base_r <= RST_WORD_C;
      rx_qual_r <= sbr_pkg::RST_QUAL;
      tx_qual_r <= sbr_pkg::RST_QUAL;
      max_len_r <= RST_WORD_C;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      master_r <= 1'b0;
    end else if (wr) begin
      unique case (reg_req.addr)
        sbr_pkg::REG_RX_BASE: rx_base_r <= reg_req.wdata;
        sbr_pkg::REG_TX_BASE: tx_base_r <= reg_req.wdata;
        sbr_pkg::REG_RX_QUAL: rx_qual_r <= reg_req.wdata[7:0];
        sbr_pkg::REG_TX_QUAL: tx_qual_r <= reg_req.wdata[7:0];
        sbr_pkg::REG_MAX_LEN: max_len_r <= reg_req.wdata;
        sbr_pkg::REG_CTRL: begin
          rx_en_r <= reg_req.wdata[sbr_pkg::CTRL_RX_EN];
          tx_en_r <= reg_req.wdata[sbr_pkg::CTRL_TX_EN];
          master_r <= reg_req.wdata[sbr_pkg::CTRL_MASTER];
        end
        default: begin
        end
      endcase
    end
  end

  // Receive ring cursor. Until first use it tracks the base, so a base
  // written after reset still takes effect.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_rx) begin
      rx_cur_r <= RST_WORD_C;
      rx_cur_ok_r <= 1'b0;
    end else if (wr && reg_req.addr == sbr_pkg::REG_RX_CUR) begin
      rx_cur_r <= reg_req.wdata;
      rx_cur_ok_r <= 1'b1;
    end else if (!rx_cur_ok_r) begin
      rx_cur_r <= rx_base_r;
      rx_cur_ok_r <= state_nxt == ST_RX_STAT;
    end else if (state_r == ST_RX_CLOSE && ack) begin
      rx_cur_r <= rx_stat_r[sbr_pkg::BD_WRAP] ? rx_base_r :
        rx_cur_r + sbr_pkg::BD_STEP;
    end
  end

  // Transmit ring cursor.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_tx) begin
      tx_cur_r <= RST_WORD_C;
      tx_cur_ok_r <= 1'b0;
    end else if (wr && reg_req.addr == sbr_pkg::REG_TX_CUR) begin
      tx_cur_r <= reg_req.wdata;
      tx_cur_ok_r <= 1'b1;
    end else if (!tx_cur_ok_r) begin
      tx_cur_r <= tx_base_r;
      tx_cur_ok_r <= state_nxt == ST_TX_STAT;
    end else if (state_r == ST_TX_CLOSE && ack) begin
      tx_cur_r <= tx_stat_r[sbr_pkg::BD_WRAP] ? tx_base_r :
        tx_cur_r + sbr_pkg::BD_STEP;
    end
  end

  // Receive buffer: pointer, down-counter and open descriptor.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_rx) begin
      rx_ptr_r <= sbr_pkg::RST_PTR;
      rx_left_r <= RST_WORD_C;
      rx_len_r <= RST_WORD_C;
      rx_stat_r <= RST_WORD_C;
      rx_open_r <= 1'b0;
    end else if (ack) begin
      unique case (state_r)
        ST_RX_STAT: begin
          rx_stat_r <= mem_rdata;
          rx_len_r <= max_len_r;
          rx_left_r <= max_len_r;
        end
        ST_RX_PHI: rx_ptr_r[31:16] <= mem_rdata;
        ST_RX_PLO: begin
          rx_ptr_r[15:0] <= mem_rdata;
          rx_open_r <= 1'b1;
        end
        ST_RX_DATA: begin
          rx_ptr_r <= rx_ptr_r + 32'h0000_0001;
          rx_left_r <= rx_left_r - 16'h0001;
        end
        ST_RX_CLOSE: rx_open_r <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  // Holding byte between the shifter and memory.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_rx) begin
      rx_hold_r <= 1'b0;
      rx_hold_byte_r <= 8'h00;
    end else if (rx_take) begin
      rx_hold_r <= 1'b1;
      rx_hold_byte_r <= rx_byte;
    end else if (state_r == ST_RX_DATA && ack) begin
      rx_hold_r <= 1'b0;
    end
  end

  // Pending close: a new close event wins over the clear of the last one.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_rx) begin
      rx_close_r <= 1'b0;
      rx_last_r <= 1'b0;
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= slave_select_in;
      if ((close_cmd || deselect) && rx_busy) begin
        rx_close_r <= 1'b1;
        if (deselect) begin
          rx_last_r <= 1'b1;
        end
      end else if (state_r == ST_RX_DATA && ack &&
          rx_left_r == 16'h0001) begin
        rx_close_r <= 1'b1;
      end else if (state_r == ST_RX_CLOSE && ack) begin
        rx_close_r <= 1'b0;
        rx_last_r <= 1'b0;
      end
    end
  end

  // Transmit buffer: pointer, down-counter and open descriptor.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_tx) begin
      tx_ptr_r <= sbr_pkg::RST_PTR;
      tx_left_r <= RST_WORD_C;
      tx_stat_r <= RST_WORD_C;
      tx_open_r <= 1'b0;
    end else if (ack) begin
      unique case (state_r)
        ST_TX_STAT: tx_stat_r <= mem_rdata;
        ST_TX_LEN: tx_left_r <= mem_rdata;
        ST_TX_PHI: tx_ptr_r[31:16] <= mem_rdata;
        ST_TX_PLO: begin
          tx_ptr_r[15:0] <= mem_rdata;
          tx_open_r <= 1'b1;
        end
        ST_TX_DATA: begin
          tx_ptr_r <= tx_ptr_r + 32'h0000_0001;
          tx_left_r <= tx_left_r - 16'h0001;
        end
        ST_TX_CLOSE: tx_open_r <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  // Byte offered to the shifter; one memory read per byte keeps odd
  // buffer pointers simple at the cost of bus bandwidth.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || init_tx) begin
      tx_hold_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else if (state_r == ST_TX_DATA && ack) begin
      tx_hold_r <= 1'b1;
      tx_byte_r <= tx_hi ? mem_rdata[15:8] : mem_rdata[7:0];
    end else if (tx_take) begin
      tx_hold_r <= 1'b0;
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rd) begin
      reg_rdata <= RST_WORD_C;
    end else begin
      unique case (reg_req.addr)
        sbr_pkg::REG_RX_BASE: reg_rdata <= rx_base_r;
        sbr_pkg::REG_TX_BASE: reg_rdata <= tx_base_r;
        sbr_pkg::REG_RX_QUAL: reg_rdata <= {8'h00, rx_qual_r};
        sbr_pkg::REG_TX_QUAL: reg_rdata <= {8'h00, tx_qual_r};
        sbr_pkg::REG_MAX_LEN: reg_rdata <= max_len_r;
        sbr_pkg::REG_RX_PTR_HI: reg_rdata <= rx_ptr_r[31:16];
        sbr_pkg::REG_RX_PTR_LO: reg_rdata <= rx_ptr_r[15:0];
        sbr_pkg::REG_RX_CUR: reg_rdata <= rx_cur_r;
        sbr_pkg::REG_RX_CNT: reg_rdata <= rx_left_r;
        sbr_pkg::REG_TX_PTR_HI: reg_rdata <= tx_ptr_r[31:16];
        sbr_pkg::REG_TX_PTR_LO: reg_rdata <= tx_ptr_r[15:0];
        sbr_pkg::REG_TX_CUR: reg_rdata <= tx_cur_r;
        sbr_pkg::REG_TX_CNT: reg_rdata <= tx_left_r;
        sbr_pkg::REG_CTRL: reg_rdata <= {13'h0000, master_r, tx_en_r,
          rx_en_r};
        sbr_pkg::REG_STAT: reg_rdata <= {10'h000, rx_last_r, rx_close_r,
          tx_hold_r, rx_hold_r, tx_open_r, rx_open_r};
        default: reg_rdata <= RST_WORD_C;
      endcase
    end
  end

endmodule : sbr_ring_dma

// ---- bench/sbr_ring_monitor.sv ----
`timescale 1ns/10ps
module sbr_ring_monitor (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port.
  input wire sbr_pkg::sbr_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata,
  // Memory master.
  input wire logic mem_req,
  input wire sbr_pkg::sbr_mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  // Shifter streams.
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready
);
  logic [15:0] base_r;
  logic [7:0] rxq_r;
  logic [7:0] txq_r;
  logic lane1;

  // Only single-lane accesses are data bytes; descriptor words use both.
  assign lane1 = mem_cmd.be == 2'h1 || mem_cmd.be == 2'h2;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      base_r <= 16'h0000;
      rxq_r <= 8'h00;
      txq_r <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == sbr_pkg::REG_RX_BASE) base_r <= reg_req.wdata;
      if (reg_req.addr == sbr_pkg::REG_RX_QUAL) rxq_r <= reg_req.wdata[7:0];
      if (reg_req.addr == sbr_pkg::REG_TX_QUAL) txq_r <= reg_req.wdata[7:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_reset_quiet: assert property ($past(sys_rst) |-> !mem_req && !tx_valid
    && !rx_ready && reg_rdata == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (!$past(reg_req.rd) |->
    reg_rdata == 16'h0000) else $error("read data outside its cycle");
  chk_base_readback: assert property (reg_req.rd && reg_req.addr ==
    sbr_pkg::REG_RX_BASE |=> reg_rdata == base_r)
    else $error("ring base read back wrong");
  chk_unmapped_zero: assert property (reg_req.rd && (reg_req.addr == 8'hFE
    || reg_req.addr == sbr_pkg::REG_CMD) |=> reg_rdata == 16'h0000)
    else $error("unmapped or command read not zero");
  chk_fc_rx_data: assert property (
    mem_req && mem_cmd.we && lane1 |-> mem_cmd.fc == rxq_r[3:0])
    else $error("receive write with wrong qualifier");
  chk_fc_tx_data: assert property (
    mem_req && !mem_cmd.we && lane1 |-> mem_cmd.fc == txq_r[3:0])
    else $error("transmit read with wrong qualifier");
  chk_mem_cmd_held: assert property (mem_req && !mem_ack && !(reg_req.wr
    && reg_req.addr == sbr_pkg::REG_CMD) |=> mem_req && $stable(mem_cmd))
    else $error("memory request changed before acknowledge");
  chk_tx_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("transmit byte dropped before it was taken");
endmodule : sbr_ring_monitor

bind sbr_ring_dma sbr_ring_monitor i_mon (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .mem_req(mem_req),
  .mem_cmd(mem_cmd),
  .mem_ack(mem_ack),
  .rx_ready(rx_ready),
  .tx_valid(tx_valid),
  .tx_byte(tx_byte),
  .tx_ready(tx_ready)
);

// ---- bench/sbr_mem_model.sv ----
`timescale 1ns/10ps
module sbr_mem_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Memory slave side.
  input wire logic mem_req,
  input wire sbr_pkg::sbr_mem_cmd_type mem_cmd,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // Wait states before each acknowledge.
  input wire logic [3:0] slow
);
  logic [15:0] mem [0:32767];
  logic [3:0] wait_r;
  logic [14:0] idx;

  assign idx = mem_cmd.addr[15:1];

  // Read data is valid only in the acknowledge cycle and flips otherwise,
  // so a sample one cycle late always sees the inverted word.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_r >= slow) begin
      mem_ack <= 1'b1;
      wait_r <= 4'h0;
      mem_rdata <= mem[idx];
      if (mem_cmd.we && mem_cmd.be[1]) mem[idx][15:8] <= mem_cmd.wdata[15:8];
      if (mem_cmd.we && mem_cmd.be[0]) mem[idx][7:0] <= mem_cmd.wdata[7:0];
    end else begin
      mem_ack <= 1'b0;
      wait_r <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : sbr_mem_model

// ---- bench/tb_spi_buffer_ring_dma.sv ----
`timescale 1ns/10ps
module tb_spi_buffer_ring_dma;
  logic ref_clk;
  logic sys_rst;
  sbr_pkg::sbr_reg_req_type reg_req;
  logic [15:0] reg_rdata;
  logic mem_req;
  sbr_pkg::sbr_mem_cmd_type mem_cmd;
  logic mem_ack;
  logic [15:0] mem_rdata;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_ready;
  logic slave_select_in;
  logic [3:0] slow;
  int mismatches;
  int checks_done;
  int cycles;

  sbr_ring_dma i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .slave_select_in(slave_select_in));
  sbr_mem_model i_mem (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .slow(slow));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // The whole run needs a few hundred cycles; this only cuts a hang.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask : reg_wr

  task automatic reg_chk(string what, logic [7:0] a, logic [15:0] e);
    @(posedge ref_clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check(what, reg_rdata, e);
  endtask : reg_chk

  task automatic poke(logic [15:0] a, logic [15:0] d);
    i_mem.mem[a[15:1]] = d;
  endtask : poke

  task automatic peek(string what, logic [15:0] a, logic [15:0] e);
    check(what, i_mem.mem[a[15:1]], e);
  endtask : peek

  task automatic rx_send(logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    for (int i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (rx_ready === 1'b1) break;
    end
    check("rx ready", {15'h0000, rx_ready}, 16'h0001);
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask : rx_send

  task automatic tx_take(logic [23:0] exp);
    @(posedge ref_clk);
    tx_ready <= 1'b1;
    for (int k = 2; k >= 0; k--) begin
      @(negedge ref_clk);
      for (int i = 0; i < 300 && tx_valid !== 1'b1; i++) @(negedge ref_clk);
      check("tx byte", {8'h00, tx_byte}, {8'h00, exp[8*k +: 8]});
      @(posedge ref_clk);
    end
    tx_ready <= 1'b0;
  endtask : tx_take

  // Waits for the owner flag of a descriptor to be handed back.
  task automatic wait_done(logic [15:0] a);
    for (int i = 0; i < 600 && i_mem.mem[a[15:1]][15] !== 1'b0; i++)
      @(posedge ref_clk);
    check("owner back", {15'h0000, i_mem.mem[a[15:1]][15]}, 16'h0000);
    repeat (3) @(posedge ref_clk);
  endtask : wait_done

  task automatic test_regs();
    reg_wr(sbr_pkg::REG_RX_BASE, 16'h0100);
    reg_wr(sbr_pkg::REG_TX_BASE, 16'h0200);
    reg_wr(sbr_pkg::REG_RX_QUAL, 16'h0018);
    reg_wr(sbr_pkg::REG_TX_QUAL, 16'h001A);
    reg_wr(sbr_pkg::REG_MAX_LEN, 16'h0004);
    reg_chk("rx base", sbr_pkg::REG_RX_BASE, 16'h0100);
    reg_chk("max len", sbr_pkg::REG_MAX_LEN, 16'h0004);
    reg_chk("rx cursor", sbr_pkg::REG_RX_CUR, 16'h0100);
    reg_chk("tx cursor", sbr_pkg::REG_TX_CUR, 16'h0200);
    reg_chk("unmapped", 8'hFE, 16'h0000);
    reg_chk("command", sbr_pkg::REG_CMD, 16'h0000);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_rx();
    poke(16'h0100, 16'h8000);
    poke(16'h0104, 16'h0000);
    poke(16'h0106, 16'h1000);
    poke(16'h0108, 16'hA000);
    poke(16'h010C, 16'h0000);
    poke(16'h010E, 16'h1010);
    poke(16'h1004, 16'hFFFF);
    slow <= 4'h2;
    reg_wr(sbr_pkg::REG_CTRL, 16'h0001);
    for (int i = 1; i <= 6; i++) rx_send(8'(8'h11 * i));
    reg_wr(sbr_pkg::REG_CMD, 16'h0004);
    wait_done(16'h0108);
    peek("rx len0", 16'h0102, 16'h0004);
    check("rx status0", i_mem.mem[16'h0080] & 16'h8000, 16'h0000);
    peek("rx word0", 16'h1000, 16'h1122);
    peek("rx word1", 16'h1002, 16'h3344);
    peek("rx guard", 16'h1004, 16'hFFFF);
    peek("rx len1", 16'h010A, 16'h0002);
    peek("rx word2", 16'h1010, 16'h5566);
    reg_chk("rx wrap", sbr_pkg::REG_RX_CUR, 16'h0100);
    // A close with no reception open must leave everything alone.
    reg_wr(sbr_pkg::REG_CMD, 16'h0004);
    repeat (20) @(posedge ref_clk);
    peek("rx len1 kept", 16'h010A, 16'h0002);
    reg_chk("rx idle cursor", sbr_pkg::REG_RX_CUR, 16'h0100);
    poke(16'h0100, 16'h8000);
    rx_send(8'h77);
    @(posedge ref_clk);
    slave_select_in <= 1'b0;
    wait_done(16'h0100);
    slave_select_in <= 1'b1;
    peek("rx len last", 16'h0102, 16'h0001);
    check("rx last", i_mem.mem[16'h0080] & 16'h0800, 16'h0800);
    check("rx byte hi", {8'h00, i_mem.mem[16'h0800][15:8]}, 16'h0077);
    reg_chk("rx next", sbr_pkg::REG_RX_CUR, 16'h0108);
    reg_wr(sbr_pkg::REG_CTRL, 16'h0000);
    reg_wr(sbr_pkg::REG_CMD, 16'h0002);
    reg_chk("rx init", sbr_pkg::REG_RX_CUR, 16'h0100);
    reg_chk("rx count init", sbr_pkg::REG_RX_CNT, 16'h0000);
    $display("test_rx done");
  endtask : test_rx

  task automatic test_tx();
    poke(16'h0200, 16'hA000);
    poke(16'h0202, 16'h0003);
    poke(16'h0204, 16'h0000);
    poke(16'h0206, 16'h2000);
    poke(16'h2000, 16'hA1B2);
    poke(16'h2002, 16'hC3D4);
    slow <= 4'h3;
    reg_wr(sbr_pkg::REG_CTRL, 16'h0002);
    tx_take(24'hA1B2C3);
    wait_done(16'h0200);
    check("tx status", i_mem.mem[16'h0100] & 16'h8000, 16'h0000);
    check("tx extra", {15'h0000, tx_valid}, 16'h0000);
    reg_chk("tx count", sbr_pkg::REG_TX_CNT, 16'h0000);
    reg_chk("tx wrap", sbr_pkg::REG_TX_CUR, 16'h0200);
    reg_wr(sbr_pkg::REG_CTRL, 16'h0000);
    // A descriptor poll may still be open; the cursor must not move under it.
    repeat (10) @(posedge ref_clk);
    reg_wr(sbr_pkg::REG_TX_CUR, 16'h0208);
    reg_wr(sbr_pkg::REG_CMD, 16'h0001);
    reg_chk("tx init", sbr_pkg::REG_TX_CUR, 16'h0200);
    reg_wr(sbr_pkg::REG_TX_QUAL, 16'h000A);
    poke(16'h0200, 16'hA000);
    reg_wr(sbr_pkg::REG_CTRL, 16'h0002);
    tx_take(24'hB2A1D4);
    wait_done(16'h0200);
    $display("test_tx done");
  endtask : test_tx

  initial begin
    sys_rst = 1'b1;
    reg_req = '0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
    slave_select_in = 1'b1;
    slow = 4'h0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_regs();
    test_rx();
    test_tx();
    print_verdict();
  end
endmodule : tb_spi_buffer_ring_dma
